// ---- verilog/sio_status_top.sv ----
// top of the status indicator outputs block
//
// Contract
// R1: registration high only when registered on LTE
// R2: searching blinks 200 ms high, 1800 low
// R3: idle blinks 234 ms high, 266 low
// R4: data transfer blinks 62 high, 63 low
// R5: voice call holds activity indicator high
// R6: operation status high after normal power-on
// R7: ring indicator idles high by default
// R8: each notice gives 120 ms low pulse
// R9: any port's notice triggers the ring
// R10: notice port selectable, USB command default
// R11: ring behaviour reconfigurable by configuration
// R12: state change restarts blink; notice restarts pulse
module sio_status_top
  import sio_pkg::*;
#(
  parameter int unsigned MS_CYCLES = SIO_MS_CYCLES,
  parameter int unsigned SEARCH_HI_MS = SIO_SEARCH_HI_MS,
  parameter int unsigned SEARCH_LO_MS = SIO_SEARCH_LO_MS,
  parameter int unsigned IDLE_HI_MS = SIO_IDLE_HI_MS,
  parameter int unsigned IDLE_LO_MS = SIO_IDLE_LO_MS,
  parameter int unsigned DATA_HI_MS = SIO_DATA_HI_MS,
  parameter int unsigned DATA_LO_MS = SIO_DATA_LO_MS,
  parameter int unsigned RING_MS = SIO_RING_LO_MS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // state from the protocol stack
  input wire sio_net_t net_state_i,
  input wire logic power_on_done_i,
  // notice events, one pulse per notice, one bit per host port
  input wire logic notice_uart_i,
  input wire logic notice_usbat_i,
  input wire logic notice_usbmd_i,
  // configuration writes
  input wire logic port_sel_we_i,
  input wire sio_port_t port_sel_i,
  input wire logic ri_mode_we_i,
  input wire sio_ri_mode_t ri_mode_i,
  // indicator pins
  output logic registration_indicator_o,
  output logic activity_indicator_o,
  output logic status_o,
  output logic ring_indicator_out_o,
  // configuration readback
  output sio_port_t notice_port_o,
  output sio_ri_mode_t ri_mode_o
);

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  sio_tick_if tick_bus ();

  sio_ms_timebase #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tb (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick(tick_bus.src)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  sio_port_t port_ff;
  sio_port_t nxt_port;
  sio_ri_mode_t mode_ff;
  sio_ri_mode_t nxt_mode;

  // the port select is only stored and read back; the ring fires for any port
  always_comb begin
    nxt_port = port_ff;
    nxt_mode = mode_ff;
    if (port_sel_we_i && port_sel_i != SIO_PORT_UART + 2'h3) begin
      nxt_port = port_sel_i; // R10
    end
    if (ri_mode_we_i) begin
      nxt_mode = ri_mode_i; // R11
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_ff <= SIO_PORT_RST;
      mode_ff <= SIO_RI_RST;
    end else begin
      port_ff <= nxt_port;
      mode_ff <= nxt_mode;
    end
  end

  assign notice_port_o = port_ff;
  assign ri_mode_o = mode_ff;

  // ----------------------------------------------------------------
  // activity blink pattern
  // ----------------------------------------------------------------
  logic [SIO_MSW-1:0] hi_len;
  logic [SIO_MSW-1:0] lo_len;
  logic blinking;

  // phase lengths for the current network state
  always_comb begin
    blinking = 1'b1;
    hi_len = SIO_MSW'(SEARCH_HI_MS);
    lo_len = SIO_MSW'(SEARCH_LO_MS);
    case (net_state_i)
      SIO_NET_SEARCH: begin
        hi_len = SIO_MSW'(SEARCH_HI_MS); // R2
        lo_len = SIO_MSW'(SEARCH_LO_MS);
      end
      SIO_NET_IDLE, SIO_NET_REG_LTE: begin
        hi_len = SIO_MSW'(IDLE_HI_MS); // R3
        lo_len = SIO_MSW'(IDLE_LO_MS);
      end
      SIO_NET_DATA: begin
        hi_len = SIO_MSW'(DATA_HI_MS); // R4
        lo_len = SIO_MSW'(DATA_LO_MS);
      end
      default: blinking = 1'b0;
    endcase
  end

  sio_net_t last_ff;
  logic [SIO_MSW-1:0] ph_ms_ff;
  logic [SIO_MSW-1:0] nxt_ph_ms;
  logic phase_hi_ff;
  logic nxt_phase_hi;
  logic act_ff;
  logic nxt_act;

  // blink counter: restarts in the high phase when the state changes
  always_comb begin
    nxt_ph_ms = ph_ms_ff;
    nxt_phase_hi = phase_hi_ff;
    if (net_state_i != last_ff) begin
      nxt_ph_ms = '0; // R12
      nxt_phase_hi = 1'b1;
    end else if (tick_bus.ms_tick) begin
      if (ph_ms_ff >= (phase_hi_ff ? hi_len : lo_len) - SIO_MSW'(1)) begin
        nxt_ph_ms = '0;
        nxt_phase_hi = ~phase_hi_ff;
      end else begin
        nxt_ph_ms = ph_ms_ff + SIO_MSW'(1);
      end
    end
    if (net_state_i == SIO_NET_VOICE) begin
      nxt_act = 1'b1; // R5
    end else if (blinking) begin
      nxt_act = nxt_phase_hi;
    end else begin
      nxt_act = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_ff <= SIO_NET_OFF;
      ph_ms_ff <= '0;
      phase_hi_ff <= 1'b1;
      act_ff <= 1'b0;
    end else begin
      last_ff <= net_state_i;
      ph_ms_ff <= nxt_ph_ms;
      phase_hi_ff <= nxt_phase_hi;
      act_ff <= nxt_act;
    end
  end

  assign activity_indicator_o = act_ff;

  // ----------------------------------------------------------------
  // registration and operation status levels
  // ----------------------------------------------------------------
  logic reg_ff;
  logic nxt_reg;
  logic stat_ff;
  logic nxt_stat;

  always_comb begin
    nxt_reg = (net_state_i == SIO_NET_REG_LTE); // R1
    nxt_stat = power_on_done_i; // R6
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_ff <= 1'b0;
      stat_ff <= 1'b0;
    end else begin
      reg_ff <= nxt_reg;
      stat_ff <= nxt_stat;
    end
  end

  assign registration_indicator_o = reg_ff;
  assign status_o = stat_ff;

  // ----------------------------------------------------------------
  // ring indicator
  // ----------------------------------------------------------------
  logic any_notice;

  assign any_notice = notice_uart_i | notice_usbat_i | notice_usbmd_i; // R9

  sio_ring_pulse #(
    .RING_MS(RING_MS)
  ) u_ring (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick(tick_bus.dst),
    .notice_i(any_notice),
    .mode_i(mode_ff),
    .ring_indicator_out_o(ring_indicator_out_o)
  );

endmodule : sio_status_top

// ---- verilog/sio_pkg.sv ----
// package of constants and types for the status indicator outputs block
package sio_pkg;

  // ----------------------------------------------------------------
  // clock rate and time base
  // ----------------------------------------------------------------
  localparam int unsigned SIO_CLK_HZ = 100_000_000;
  localparam int unsigned SIO_MS_CYCLES = SIO_CLK_HZ / 1000;

  // ----------------------------------------------------------------
  // blink phase and ring pulse times in milliseconds
  // ----------------------------------------------------------------
  localparam int unsigned SIO_SEARCH_HI_MS = 200;
  localparam int unsigned SIO_SEARCH_LO_MS = 1800;
  localparam int unsigned SIO_IDLE_HI_MS = 234;
  localparam int unsigned SIO_IDLE_LO_MS = 266;
  localparam int unsigned SIO_DATA_HI_MS = 62;
  localparam int unsigned SIO_DATA_LO_MS = 63;
  localparam int unsigned SIO_RING_LO_MS = 120;

  // ----------------------------------------------------------------
  // ms counter width (covers the longest phase)
  // ----------------------------------------------------------------
  localparam int unsigned SIO_MSW = 11;

  // ----------------------------------------------------------------
  // network states reported by the protocol stack
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SIO_NET_OFF      = 3'h0,
    SIO_NET_SEARCH   = 3'h1,
    SIO_NET_IDLE     = 3'h2,
    SIO_NET_DATA     = 3'h3,
    SIO_NET_VOICE    = 3'h4,
    SIO_NET_REG_LTE  = 3'h5
  } sio_net_t;

  // ----------------------------------------------------------------
  // ring indicator modes and notice destination ports
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SIO_RI_PULSE = 2'h0,
    SIO_RI_HIGH  = 2'h1,
    SIO_RI_LOW   = 2'h2,
    SIO_RI_OFF   = 2'h3
  } sio_ri_mode_t;

  typedef enum logic [1:0] {
    SIO_PORT_UART  = 2'h0,
    SIO_PORT_USBAT = 2'h1,
    SIO_PORT_USBMD = 2'h2
  } sio_port_t;

  localparam sio_port_t SIO_PORT_RST = SIO_PORT_USBAT;
  localparam sio_ri_mode_t SIO_RI_RST = SIO_RI_PULSE;

endpackage : sio_pkg

// ---- verilog/sio_tick_if.sv ----
// interface carrying the millisecond tick between the block's modules
interface sio_tick_if;
  logic ms_tick;

  modport src (output ms_tick);
  modport dst (input ms_tick);
endinterface : sio_tick_if

// ---- verilog/sio_ms_timebase.sv ----
// millisecond tick generator
module sio_ms_timebase
  import sio_pkg::*;
#(
  parameter int unsigned MS_CYCLES = SIO_MS_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // tick out
  sio_tick_if.src tick
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // count cycles and pulse once per millisecond
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff + 32'h1;
    if (cnt_ff >= 32'(MS_CYCLES - 1)) begin
      nxt_cnt = 32'h0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick.ms_tick = tick_ff;

endmodule : sio_ms_timebase

// ---- verilog/sio_ring_pulse.sv ----
// ring indicator pulse generator
module sio_ring_pulse
  import sio_pkg::*;
#(
  parameter int unsigned RING_MS = SIO_RING_LO_MS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // time base
  sio_tick_if.dst tick,
  // control
  input wire logic notice_i,
  input wire sio_ri_mode_t mode_i,
  // pin
  output logic ring_indicator_out_o
);

  logic [SIO_MSW-1:0] ms_ff;
  logic [SIO_MSW-1:0] nxt_ms;
  logic busy_ff;
  logic nxt_busy;
  logic ri_ff;
  logic nxt_ri;

  // a fresh notice restarts the low interval; the interval counts whole ms ticks
  always_comb begin
    nxt_ms = ms_ff;
    nxt_busy = busy_ff;
    if (notice_i && mode_i == SIO_RI_PULSE) begin
      nxt_busy = 1'b1; // R8
      nxt_ms = '0; // R12
    end else if (busy_ff && tick.ms_tick) begin
      if (ms_ff >= SIO_MSW'(RING_MS - 1)) begin
        nxt_busy = 1'b0;
        nxt_ms = '0;
      end else begin
        nxt_ms = ms_ff + SIO_MSW'(1);
      end
    end
    if (mode_i != SIO_RI_PULSE) begin
      nxt_busy = 1'b0;
    end
    case (mode_i)
      SIO_RI_PULSE: nxt_ri = ~nxt_busy; // R7
      SIO_RI_HIGH: nxt_ri = 1'b1; // R11
      SIO_RI_LOW: nxt_ri = 1'b0;
      default: nxt_ri = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_ff <= '0;
      busy_ff <= 1'b0;
      ri_ff <= 1'b1;
    end else begin
      ms_ff <= nxt_ms;
      busy_ff <= nxt_busy;
      ri_ff <= nxt_ri;
    end
  end

  assign ring_indicator_out_o = ri_ff;

endmodule : sio_ring_pulse

// ---- dv/sio_status_assertions.sv ----
// checker on the ports of the status indicator outputs block
module sio_status_checker
  import sio_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10,
  parameter int unsigned RING_MS = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // block inputs
  input wire sio_net_t net_state_i,
  input wire logic power_on_done_i,
  input wire logic notice_uart_i,
  input wire logic notice_usbat_i,
  input wire logic notice_usbmd_i,
  input wire logic port_sel_we_i,
  input wire sio_port_t port_sel_i,
  input wire logic ri_mode_we_i,
  input wire sio_ri_mode_t ri_mode_i,
  // block outputs
  input wire logic registration_indicator_o,
  input wire logic activity_indicator_o,
  input wire logic status_o,
  input wire logic ring_indicator_out_o,
  input wire sio_port_t notice_port_o,
  input wire sio_ri_mode_t ri_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic any_ntc;
  logic [15:0] lo_cnt_ff;
  logic [15:0] nxt_lo_cnt;
  assign any_ntc = notice_uart_i | notice_usbat_i | notice_usbmd_i;
  // ring low cycles since the last notice, pulse mode only
  always_comb begin
    nxt_lo_cnt = ring_indicator_out_o ? 16'h0 : lo_cnt_ff + 16'h1;
    if (any_ntc || ri_mode_o != SIO_RI_PULSE) nxt_lo_cnt = 16'h0;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lo_cnt_ff <= 16'h0;
    else lo_cnt_ff <= nxt_lo_cnt;
  end
  a_reg_lte_high: assert property ((net_state_i == SIO_NET_REG_LTE) [*2] |->
    registration_indicator_o) else $error("registration low while registered");
  a_reg_other_low: assert property ((net_state_i != SIO_NET_REG_LTE) [*2] |->
    !registration_indicator_o) else $error("registration high while not registered");
  a_voice_steady: assert property ((net_state_i == SIO_NET_VOICE) [*2] |->
    activity_indicator_o) else $error("activity low in voice call");
  a_state_restart: assert property (net_state_i != $past(net_state_i) &&
    net_state_i != SIO_NET_OFF |=> activity_indicator_o) else $error("blink not restarted");
  a_status_follow: assert property ($changed(power_on_done_i) |=>
    status_o == $past(power_on_done_i)) else $error("status does not follow power-on");
  a_notice_drops: assert property (any_ntc && ri_mode_o == SIO_RI_PULSE && !ri_mode_we_i
    |=> !ring_indicator_out_o) else $error("notice gave no ring pulse");
  a_ring_hi_modes: assert property ((ri_mode_o inside {SIO_RI_HIGH, SIO_RI_OFF}) [*2]
    |-> ring_indicator_out_o) else $error("ring low in a high mode");
  a_pulse_bounded: assert property (lo_cnt_ff <= RING_MS * MS_CYCLES + 1)
    else $error("ring pulse too long");
  a_port_write: assert property (port_sel_we_i && port_sel_i != 2'h3 |=>
    notice_port_o == $past(port_sel_i)) else $error("port select not taken");
  a_port_three_kept: assert property (port_sel_we_i && port_sel_i == 2'h3 |=>
    $stable(notice_port_o)) else $error("port value three not ignored");
endmodule : sio_status_checker

bind sio_status_top sio_status_checker #(.MS_CYCLES(MS_CYCLES), .RING_MS(RING_MS)) u_chk (.*);

// ---- dv/sio_led_host.sv ----
// led and host side model: measures indicator run lengths in cycles
module sio_led_host (
  // clock
  input wire logic sys_clk_i,
  // indicator pins
  input wire logic act_i,
  input wire logic ri_i,
  // last completed runs
  output int act_hi_o,
  output int act_lo_o,
  output int ri_lo_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int run;
  int ri_run;
  bit act_q;
  // record each activity run when the level turns; ring low runs only, when ring goes high
  always @(posedge sys_clk_i) begin
    if (act_i !== act_q) begin
      if (act_q) act_hi_o <= run;
      else act_lo_o <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    act_q <= act_i;
    if (ri_i === 1'b0) ri_run <= ri_run + 1;
    else if (ri_run != 0) begin
      ri_lo_o <= ri_run;
      ri_run <= 0;
    end
  end
endmodule : sio_led_host

// ---- dv/status_indicator_outputs_test.sv ----
// self-checking bench for the status indicator outputs block
module status_indicator_outputs_test;
  import sio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MSC = 10;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  sio_net_t net = SIO_NET_OFF;
  logic pwr = 1'b0;
  logic [2:0] ntc = 3'h0;
  logic psel_we = 1'b0;
  sio_port_t psel = SIO_PORT_UART;
  logic mode_we = 1'b0;
  sio_ri_mode_t mode = SIO_RI_PULSE;
  logic reg_o, act_o, stat_o, ri_o;
  sio_port_t port_o;
  sio_ri_mode_t mode_o;
  int act_hi, act_lo, ri_lo;
  int fails = 0;
  int num_checks = 0;
  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;
  // data transfer phases keep their real lengths so the rapid pattern is checked as built
  sio_status_top #(.MS_CYCLES(MSC), .SEARCH_HI_MS(4), .SEARCH_LO_MS(6), .IDLE_HI_MS(3),
    .IDLE_LO_MS(5), .RING_MS(4)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .net_state_i(net), .power_on_done_i(pwr),
    .notice_uart_i(ntc[0]), .notice_usbat_i(ntc[1]), .notice_usbmd_i(ntc[2]),
    .port_sel_we_i(psel_we), .port_sel_i(psel), .ri_mode_we_i(mode_we), .ri_mode_i(mode),
    .registration_indicator_o(reg_o), .activity_indicator_o(act_o), .status_o(stat_o),
    .ring_indicator_out_o(ri_o), .notice_port_o(port_o), .ri_mode_o(mode_o));
  sio_led_host u_host (.sys_clk_i(sys_clk_i), .act_i(act_o), .ri_i(ri_o),
    .act_hi_o(act_hi), .act_lo_o(act_lo), .ri_lo_o(ri_lo));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic t_reset();
    chk("reg", 0, reg_o);
    chk("status", 0, stat_o);
    chk("ring", 1, ri_o);
    chk("port", 1, port_o);
    $display("test reset done");
  endtask : t_reset
  task automatic t_reg();
    for (int i = 0; i < 6; i++) begin
      net = sio_net_t'(i);
      cyc(2);
      chk("reg", i == 5, reg_o);
    end
    $display("test registration done");
  endtask : t_reg
  task automatic t_blink(input sio_net_t st, input int hi, input int lo);
    net = st;
    cyc(1);
    chk("restart", 1, act_o);
    cyc(2 * (hi + lo) * MSC + 5);
    chk("act hi", hi * MSC, act_hi);
    chk("act lo", lo * MSC, act_lo);
    $display("test blink %0d done", st);
  endtask : t_blink
  task automatic t_voice_status();
    net = SIO_NET_VOICE;
    pwr = 1'b1;
    cyc(60);
    chk("voice", 1, act_o);
    chk("status", 1, stat_o);
    net = SIO_NET_OFF;
    cyc(2);
    chk("off", 0, act_o);
    $display("test voice and status done");
  endtask : t_voice_status
  task automatic t_ring();
    for (int p = 0; p < 3; p++) begin
      ntc = 3'h1 << p;
      cyc(1);
      ntc = 3'h0;
      chk("ri low", 0, ri_o);
      cyc(50);
      chk("ri len", 1, ri_lo >= 30 && ri_lo <= 41);
    end
    ntc = 3'h1;
    cyc(1);
    ntc = 3'h0;
    cyc(20);
    ntc = 3'h4;
    cyc(1);
    ntc = 3'h0;
    cyc(60);
    chk("ri restart", 1, ri_lo >= 50);
    $display("test ring done");
  endtask : t_ring
  task automatic t_cfg();
    sio_port_t exp;
    exp = port_o;
    for (int m = 1; m < 5; m++) begin
      mode = sio_ri_mode_t'(m % 4);
      mode_we = 1'b1;
      psel = sio_port_t'(m % 4);
      psel_we = 1'b1;
      cyc(1);
      mode_we = 1'b0;
      psel_we = 1'b0;
      exp = (m == 3) ? exp : sio_port_t'(m % 4);
      chk("port", exp, port_o);
      chk("mode", m % 4, mode_o);
      ntc = 3'h2;
      cyc(1);
      ntc = 3'h0;
      cyc(2);
      chk("ri mode", m % 2, ri_o);
    end
    $display("test config done");
  endtask : t_cfg
  // watchdog against a hang
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    cyc(4);
    t_reset();
    cyc(1);
    rst_n_i = 1'b1;
    t_reg();
    t_blink(SIO_NET_SEARCH, 4, 6);
    t_blink(SIO_NET_DATA, SIO_DATA_HI_MS, SIO_DATA_LO_MS);
    t_blink(SIO_NET_IDLE, 3, 5);
    t_blink(SIO_NET_REG_LTE, 3, 5);
    t_voice_status();
    t_ring();
    t_cfg();
    summarize();
  end
endmodule : status_indicator_outputs_test
